// File: rx_hpoh_path_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module rx_hpoh_path_monitor (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_strobe,
  input  wire logic [7:0]  rx_j1,
  input  wire logic [7:0]  rx_c2,
  input  wire logic [7:0]  rx_g1,
  input  wire logic [7:0]  rx_k3,
  input  wire logic [7:0]  rx_n1,
  input  wire logic [7:0]  rx_h4,
  input  wire logic [3:0]  rx_b3_errors,
  output logic             label_mismatch_alarm,
  output logic             path_unequipped_alarm,
  output logic             defect_insert,
  output logic             trace_mismatch,
  output logic             trace_indicator_output
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  logic [7:0]  cfg1_q, cfg1_d, cfg2_q, cfg2_d, expc2_q, expc2_d;
  logic [7:0]  rxc2_q, rxc2_d, k3_q, k3_d, k3_last_q, k3_last_d;
  logic [3:0]  g1_q, g1_d;
  logic [1:0]  k3_rep_q, k3_rep_d, sr_q, sr_d;
  logic [15:0] b3_cnt_q, b3_cnt_d, b3_buf_q, b3_buf_d;
  logic [15:0] rei_cnt_q, rei_cnt_d, rei_buf_q, rei_buf_d;
  logic [5:0]  ptr_q, ptr_d;
  logic        acc_q, acc_d, pclr_q, pclr_d;
  logic [2:0]  slm_cnt_q, slm_cnt_d, uq_cnt_q, uq_cnt_d;
  logic        slm_q, slm_d, uq_q, uq_d, ins_q, ins_d;
  logic        tmis_q, tmis_d, ind_q, ind_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [7:0]  mem [path_monitor_pkg::STR_DEPTH];
  logic [7:0]  idx;
  logic        hit, setup, wr, rd, mem_we, step, qual;
  logic [15:0] b3_inc, rei_inc;
  logic [2:0]  slm_thr;
  logic [5:0]  last;

  // Byte address decode; only aligned words in the block's window hit.
  assign idx   = paddr[9:2];
  assign hit   = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00 &&
                 idx >= path_monitor_pkg::CFG1_IDX && idx <= path_monitor_pkg::TDAT_IDX;
  assign setup = psel && !penable;
  assign wr    = psel && penable && pready_q && pwrite && hit;
  assign rd    = psel && penable && pready_q && !pwrite && hit;

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------

  // Computes the next value of the configuration, capture, counter, alarm and trace registers from bus and frame events.
  always_comb begin
    cfg1_d    = cfg1_q;
    cfg2_d    = cfg2_q;
    expc2_d   = expc2_q;
    rxc2_d    = rxc2_q;
    k3_d      = k3_q;
    k3_last_d = k3_last_q;
    k3_rep_d  = k3_rep_q;
    g1_d      = g1_q;
    acc_d     = acc_q;
    pclr_d    = pclr_q;
    ptr_d     = ptr_q;
    slm_cnt_d = slm_cnt_q;
    slm_d     = slm_q;
    uq_cnt_d  = uq_cnt_q;
    uq_d      = uq_q;
    tmis_d    = tmis_q;
    mem_we    = 1'b0;
    // Counting unit for each counter.
    b3_inc  = cfg1_q[path_monitor_pkg::B3_UNIT_BIT] ? {15'h0000, rx_b3_errors != 4'h0}
                                                    : {12'h000, rx_b3_errors};
    rei_inc = cfg1_q[path_monitor_pkg::REI_UNIT_BIT] ? {15'h0000, rx_g1[7:4] != 4'h0}
                                                     : {12'h000, rx_g1[7:4]};
    b3_cnt_d  = frame_strobe ? b3_cnt_q + b3_inc : b3_cnt_q;
    rei_cnt_d = frame_strobe ? rei_cnt_q + rei_inc : rei_cnt_q;
    b3_buf_d  = b3_buf_q;
    rei_buf_d = rei_buf_q;
    slm_thr = cfg1_q[path_monitor_pkg::SLM_CNT_BIT] ? path_monitor_pkg::SLM_HIGH
                                                    : path_monitor_pkg::SLM_LOW;
    last = cfg1_q[path_monitor_pkg::STR_LEN_BIT] ? path_monitor_pkg::LEN_LONG
                                                 : path_monitor_pkg::LEN_SHORT;
    qual = rx_c2 == 8'h00 &&
           (!cfg2_q[path_monitor_pkg::B3_CRIT_BIT] || rx_b3_errors == 4'h0) &&
           (!cfg2_q[path_monitor_pkg::N1_CRIT_BIT] || rx_n1 == 8'h00) &&
           (cfg2_q[1:0] != path_monitor_pkg::J1_CRIT_ZERO || rx_j1 == 8'h00);
    // Pointer steps by processor access or by frame compare.
    step = acc_q ? ((wr || rd) && idx == path_monitor_pkg::TDAT_IDX)
                 : frame_strobe;
    // Per-frame overhead capture and alarm integration.
    if (frame_strobe) begin
      rxc2_d = rx_c2;
      g1_d   = rx_g1[3:0];
      if (rx_k3 == k3_last_q) begin
        k3_rep_d = (k3_rep_q == path_monitor_pkg::K3_REPEAT) ? k3_rep_q : k3_rep_q + 2'h1;
      end else begin
        k3_rep_d = 2'h1;
      end
      k3_last_d = rx_k3;
      if (k3_rep_d == path_monitor_pkg::K3_REPEAT) begin
        k3_d = rx_k3;
      end
      if ((rx_c2 != expc2_q) != slm_q) begin
        slm_cnt_d = slm_cnt_q + 3'h1;
        if (slm_cnt_d >= slm_thr) begin
          slm_d     = !slm_q;
          slm_cnt_d = 3'h0;
        end
      end else begin
        slm_cnt_d = 3'h0;
      end
      if (qual) begin
        uq_cnt_d = (uq_cnt_q == path_monitor_pkg::UNEQ_FRMS) ? uq_cnt_q : uq_cnt_q + 3'h1;
      end else begin
        uq_cnt_d = 3'h0;
      end
      uq_d = uq_cnt_d == path_monitor_pkg::UNEQ_FRMS;
      if (!acc_q) begin
        tmis_d = mem[ptr_q] != rx_j1;
      end
    end
    if (step) begin
      ptr_d = (ptr_q >= last) ? 6'h00 : ptr_q + 6'h01;
    end
    // Register writes; snapshot writes clear the live counter, or load it with the count of a frame in the same cycle.
    if (wr) begin
      unique case (idx)
        path_monitor_pkg::CFG1_IDX:  cfg1_d  = pwdata[7:0];
        path_monitor_pkg::CFG2_IDX:  cfg2_d  = pwdata[7:0];
        path_monitor_pkg::EXPC2_IDX: expc2_d = pwdata[7:0];
        path_monitor_pkg::B3HI_IDX: begin
          b3_buf_d = b3_cnt_q;
          b3_cnt_d = frame_strobe ? b3_inc : path_monitor_pkg::CNT_RST;
        end
        path_monitor_pkg::REIHI_IDX: begin
          rei_buf_d = rei_cnt_q;
          rei_cnt_d = frame_strobe ? rei_inc : path_monitor_pkg::CNT_RST;
        end
        path_monitor_pkg::TCTL_IDX: begin
          acc_d  = pwdata[path_monitor_pkg::ACC_BIT];
          pclr_d = pwdata[path_monitor_pkg::PCLR_BIT];
          if (pwdata[path_monitor_pkg::PCLR_BIT] && !pclr_q) begin
            ptr_d = 6'h00;
          end
        end
        path_monitor_pkg::TDAT_IDX:  mem_we = 1'b1;
        default: ;
      endcase
    end
  end

  // Outgoing RDI request and indicator pulse shaping.
  always_comb begin
    ins_d = (slm_q && cfg2_q[path_monitor_pkg::RDI_SLM_BIT]) ||
            (uq_q && cfg2_q[path_monitor_pkg::RDI_UNEQ_BIT]);
    ind_d = frame_strobe || sr_q[0];
    sr_d  = {frame_strobe && cfg2_q[path_monitor_pkg::PULSE_BIT] && rx_h4[1:0] == 2'b00, sr_q[1]};
  end

  // Read data is prepared in the setup phase for a zero-wait answer.
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup && !hit;
    prdata_d  = 32'h0000_0000;
    if (setup && hit) begin
      unique case (idx)
        path_monitor_pkg::CFG1_IDX:  prdata_d[7:0] = cfg1_q;
        path_monitor_pkg::CFG2_IDX:  prdata_d[7:0] = cfg2_q;
        path_monitor_pkg::EXPC2_IDX: prdata_d[7:0] = expc2_q;
        path_monitor_pkg::RXC2_IDX:  prdata_d[7:0] = rxc2_q;
        path_monitor_pkg::K3_IDX:    prdata_d[7:0] = k3_q;
        path_monitor_pkg::G1_IDX:    prdata_d[3:0] = g1_q;
        path_monitor_pkg::B3LO_IDX:  prdata_d[7:0] = b3_buf_q[7:0];
        path_monitor_pkg::B3HI_IDX:  prdata_d[7:0] = b3_buf_q[15:8];
        path_monitor_pkg::REILO_IDX: prdata_d[7:0] = rei_buf_q[7:0];
        path_monitor_pkg::REIHI_IDX: prdata_d[7:0] = rei_buf_q[15:8];
        path_monitor_pkg::TDAT_IDX:  prdata_d[7:0] = mem[ptr_q];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------

  // Registers all control and status state.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg1_q    <= path_monitor_pkg::CFG_RST;
      cfg2_q    <= path_monitor_pkg::CFG_RST;
      expc2_q   <= path_monitor_pkg::EXPC2_RST;
      rxc2_q    <= 8'h00;
      k3_q      <= 8'h00;
      k3_last_q <= 8'h00;
      k3_rep_q  <= 2'h0;
      g1_q      <= 4'h0;
      b3_cnt_q  <= path_monitor_pkg::CNT_RST;
      b3_buf_q  <= path_monitor_pkg::CNT_RST;
      rei_cnt_q <= path_monitor_pkg::CNT_RST;
      rei_buf_q <= path_monitor_pkg::CNT_RST;
      ptr_q     <= 6'h00;
      acc_q     <= path_monitor_pkg::ACC_RST;
      pclr_q    <= 1'b0;
      slm_cnt_q <= 3'h0;
      slm_q     <= 1'b0;
      uq_cnt_q  <= 3'h0;
      uq_q      <= 1'b0;
      ins_q     <= 1'b0;
      tmis_q    <= 1'b0;
      ind_q     <= 1'b0;
      sr_q      <= 2'h0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      cfg1_q    <= cfg1_d;
      cfg2_q    <= cfg2_d;
      expc2_q   <= expc2_d;
      rxc2_q    <= rxc2_d;
      k3_q      <= k3_d;
      k3_last_q <= k3_last_d;
      k3_rep_q  <= k3_rep_d;
      g1_q      <= g1_d;
      b3_cnt_q  <= b3_cnt_d;
      b3_buf_q  <= b3_buf_d;
      rei_cnt_q <= rei_cnt_d;
      rei_buf_q <= rei_buf_d;
      ptr_q     <= ptr_d;
      acc_q     <= acc_d;
      pclr_q    <= pclr_d;
      slm_cnt_q <= slm_cnt_d;
      slm_q     <= slm_d;
      uq_cnt_q  <= uq_cnt_d;
      uq_q      <= uq_d;
      ins_q     <= ins_d;
      tmis_q    <= tmis_d;
      ind_q     <= ind_d;
      sr_q      <= sr_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Expected trace string storage, cleared at reset.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < path_monitor_pkg::STR_DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (mem_we) begin
      mem[ptr_q] <= pwdata[7:0];
    end
  end

  // Every output is taken straight from its flip-flop.
  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign label_mismatch_alarm   = slm_q;
  assign path_unequipped_alarm  = uq_q;
  assign defect_insert          = ins_q;
  assign trace_mismatch         = tmis_q;
  assign trace_indicator_output = ind_q;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  rdi_on_slm_a: assert property (slm_q && cfg2_q[6] |=> ins_q)
    else $error("RDI not inserted on mismatch alarm");
  ind_double_a: assert property (frame_strobe && cfg2_q[5] && rx_h4[1:0] == 2'b00 && sr_q == 2'h0
    |=> ind_q ##1 !ind_q ##1 ind_q)
    else $error("Multiframe double pulse missing");
  ind_single_a: assert property (frame_strobe && !cfg2_q[5] && sr_q == 2'h0
    |=> ind_q ##1 !ind_q ##1 !ind_q)
    else $error("Single pulse malformed");
  rdi_off_a: assert property (!(slm_q && cfg2_q[6]) && !(uq_q && cfg2_q[4]) |=> !ins_q)
    else $error("RDI inserted without enabled alarm");
  uneq_b3_a: assert property (frame_strobe && cfg2_q[3] && rx_b3_errors != 4'h0
    |=> !uq_q && uq_cnt_q == 3'h0)
    else $error("Unequipped raised despite B3 errors");
  uneq_n1_a: assert property (frame_strobe && cfg2_q[2] && rx_n1 != 8'h00 |=> !uq_q)
    else $error("Unequipped raised despite non-zero N1");
  uneq_j1_a: assert property (frame_strobe && cfg2_q[1:0] == 2'b10 && rx_j1 != 8'h00
    |=> !uq_q)
    else $error("Unequipped raised despite non-zero J1");
  ptr_clear_a: assert property (wr && idx == 8'h8a && pwdata[0] && !pclr_q |=> ptr_q == 6'h00)
    else $error("Pointer not cleared on rising clear bit");
  b3_snap_a: assert property (wr && idx == 8'h87 |=> b3_buf_q == $past(b3_cnt_q) && b3_cnt_q <= 16'h0008)
    else $error("B3 snapshot wrong");
  rei_bit_a: assert property (frame_strobe && !cfg1_q[1] && !(wr && idx == 8'h89)
    |=> rei_cnt_q == $past(rei_cnt_q) + {12'h000, $past(rx_g1[7:4])})
    else $error("REI bit count wrong");

  slm_raise_c: cover property (!slm_q ##1 slm_q);
  uneq_raise_c: cover property (!uq_q ##1 uq_q);
  rei_snap_c: cover property (wr && idx == 8'h89 && rei_cnt_q != 16'h0000);

endmodule

`default_nettype wire

// File: path_monitor_pkg.sv
package path_monitor_pkg;

  // ----------------------------------------------------------------
  // Register indexes; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG1_IDX  = 8'h80;
  localparam logic [7:0] CFG2_IDX  = 8'h81;
  localparam logic [7:0] EXPC2_IDX = 8'h82;
  localparam logic [7:0] RXC2_IDX  = 8'h83;
  localparam logic [7:0] K3_IDX    = 8'h84;
  localparam logic [7:0] G1_IDX    = 8'h85;
  localparam logic [7:0] B3LO_IDX  = 8'h86;
  localparam logic [7:0] B3HI_IDX  = 8'h87;
  localparam logic [7:0] REILO_IDX = 8'h88;
  localparam logic [7:0] REIHI_IDX = 8'h89;
  localparam logic [7:0] TCTL_IDX  = 8'h8a;
  localparam logic [7:0] TDAT_IDX  = 8'h8b;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int SLM_CNT_BIT  = 6;
  localparam int STR_LEN_BIT  = 5;
  localparam int B3_UNIT_BIT  = 2;
  localparam int REI_UNIT_BIT = 1;
  localparam int RDI_SLM_BIT  = 6;
  localparam int PULSE_BIT    = 5;
  localparam int RDI_UNEQ_BIT = 4;
  localparam int B3_CRIT_BIT  = 3;
  localparam int N1_CRIT_BIT  = 2;
  localparam int ACC_BIT      = 1;
  localparam int PCLR_BIT     = 0;
  localparam logic [1:0] J1_CRIT_ZERO = 2'b10;

  // ----------------------------------------------------------------
  // Reset values and frame counts.
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] EXPC2_RST  = 8'h00;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic       ACC_RST    = 1'b1;
  localparam logic [2:0] SLM_LOW    = 3'h3;
  localparam logic [2:0] SLM_HIGH   = 3'h5;
  localparam logic [2:0] UNEQ_FRMS  = 3'h5;
  localparam logic [1:0] K3_REPEAT  = 2'h3;
  localparam logic [5:0] LEN_SHORT  = 6'h0f;
  localparam logic [5:0] LEN_LONG   = 6'h3f;
  localparam int         STR_DEPTH  = 64;

endpackage

// File: rx_hpoh_path_monitor_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module rx_hpoh_path_monitor_tb_top;
  logic        mclk, rst_b, psel, penable, pwrite, frame_strobe, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, lma, pua, dins, tmis, tind;
  logic [7:0]  rx_j1, rx_c2, rx_g1, rx_k3, rx_n1, rx_h4;
  logic [3:0]  rx_b3_errors;
  int          fail_count, checks_done, cycles, pulses, p, i, j;
  logic [7:0]  crit [4] = '{8'h08, 8'h04, 8'h02, 8'h00};
  logic [7:0]  pcfg [3] = '{8'h00, 8'h20, 8'h20};
  logic [7:0]  ph4  [3] = '{8'h00, 8'h00, 8'h01};
  int          pexp [3] = '{1, 2, 1};

  rx_hpoh_path_monitor rx_hpoh_path_monitor_i (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_strobe(frame_strobe),
    .rx_j1(rx_j1), .rx_c2(rx_c2), .rx_g1(rx_g1), .rx_k3(rx_k3), .rx_n1(rx_n1), .rx_h4(rx_h4),
    .rx_b3_errors(rx_b3_errors), .label_mismatch_alarm(lma), .path_unequipped_alarm(pua),
    .defect_insert(dins), .trace_mismatch(tmis), .trace_indicator_output(tind));

  // ----------------------------------------------------------------
  // Clock, cycle limit and indicator pulse counting.
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // A hang is cut short here and counted as a mismatch.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (tind === 1'b1) pulses <= pulses + 1;
    if (cycles == 8000) begin
      fail_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] data);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, data};
    @(posedge mclk);
    penable <= 1'b1;
    // Only pready or the bench's cycle limit ends this wait.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    apb(1'b1, idx, data);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp});
  endtask

  // One frame strobe with its overhead bytes, then time for the outputs to settle.
  task automatic frame(input logic [7:0] c2, g1, n1, j1, h4, k3, input logic [3:0] b3);
    @(posedge mclk);
    frame_strobe <= 1'b1;
    rx_c2 <= c2;
    rx_g1 <= g1;
    rx_n1 <= n1;
    rx_j1 <= j1;
    rx_h4 <= h4;
    rx_k3 <= k3;
    rx_b3_errors <= b3;
    @(posedge mclk);
    frame_strobe <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, frame_strobe, paddr, pwdata} = '0;
    {rx_j1, rx_c2, rx_g1, rx_k3, rx_n1, rx_h4, rx_b3_errors} = '0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rdchk(path_monitor_pkg::EXPC2_IDX, 8'h00);
    rdchk(path_monitor_pkg::B3HI_IDX, 8'h00);
    apb(1'b0, 8'h90, 8'h00);
    check(32'(err), 32'h1);
    $display("test reset done");
    // Mismatching labels raise the alarm on the third frame.
    wr(path_monitor_pkg::EXPC2_IDX, 8'h13);
    rdchk(path_monitor_pkg::EXPC2_IDX, 8'h13);
    wr(path_monitor_pkg::RXC2_IDX, 8'h77);
    wr(path_monitor_pkg::CFG2_IDX, 8'h40);
    for (i = 0; i < 3; i++) begin
      frame(8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4'h0);
      check(32'(lma), 32'(i == 2));
    end
    check(32'(dins), 32'h1);
    rdchk(path_monitor_pkg::RXC2_IDX, 8'h22);
    wr(path_monitor_pkg::CFG2_IDX, 8'h00);
    repeat (3) @(posedge mclk);
    check(32'(dins), 32'h0);
    $display("test label done");
    // Counters in bit and block units, with snapshot and clear.
    wr(path_monitor_pkg::B3HI_IDX, 8'h00);
    wr(path_monitor_pkg::REIHI_IDX, 8'h00);
    frame(8'h22, 8'h5b, 8'h00, 8'h00, 8'h00, 8'h00, 4'h3);
    frame(8'h22, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 4'h2);
    wr(path_monitor_pkg::B3HI_IDX, 8'h00);
    wr(path_monitor_pkg::REIHI_IDX, 8'h00);
    frame(8'h22, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00, 4'h8);
    rdchk(path_monitor_pkg::B3LO_IDX, 8'h05);
    rdchk(path_monitor_pkg::B3HI_IDX, 8'h00);
    rdchk(path_monitor_pkg::REILO_IDX, 8'h08);
    rdchk(path_monitor_pkg::REIHI_IDX, 8'h00);
    wr(path_monitor_pkg::CFG1_IDX, 8'h06);
    wr(path_monitor_pkg::B3HI_IDX, 8'h00);
    wr(path_monitor_pkg::REIHI_IDX, 8'h00);
    frame(8'h22, 8'h5b, 8'h00, 8'h00, 8'h00, 8'h00, 4'h3);
    frame(8'h22, 8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, 4'h0);
    frame(8'h22, 8'h7a, 8'h00, 8'h00, 8'h00, 8'h00, 4'h1);
    wr(path_monitor_pkg::B3HI_IDX, 8'h00);
    wr(path_monitor_pkg::REIHI_IDX, 8'h00);
    rdchk(path_monitor_pkg::B3LO_IDX, 8'h02);
    rdchk(path_monitor_pkg::REILO_IDX, 8'h02);
    apb(1'b0, path_monitor_pkg::G1_IDX, 8'h00);
    check(32'(rd[3:0]), 32'ha);
    $display("test counters done");
    // The received K3 value moves only after three equal bytes.
    frame(8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5c, 4'h0);
    frame(8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5c, 4'h0);
    rdchk(path_monitor_pkg::K3_IDX, 8'h00);
    frame(8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5c, 4'h0);
    rdchk(path_monitor_pkg::K3_IDX, 8'h5c);
    $display("test k3 done");
    // Each unequipped criterion blocks the alarm until five clean frames pass.
    wr(path_monitor_pkg::EXPC2_IDX, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(path_monitor_pkg::CFG2_IDX, crit[i] | 8'h10);
      repeat (5) frame(8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 4'h1);
      check(32'(pua), 32'(i == 3));
      for (j = 0; j < 5; j++) begin
        frame(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4'h0);
        check(32'(pua), 32'(j == 4 || i == 3));
      end
      check(32'(dins), 32'h1);
    end
    wr(path_monitor_pkg::CFG2_IDX, 8'h00);
    repeat (3) @(posedge mclk);
    check(32'(dins), 32'h0);
    $display("test unequipped done");
    // Single and double indicator pulses.
    for (i = 0; i < 3; i++) begin
      wr(path_monitor_pkg::CFG2_IDX, pcfg[i]);
      p = pulses;
      frame(8'h00, 8'h00, 8'h00, 8'h00, ph4[i], 8'h00, 4'h0);
      check(32'(pulses - p), 32'(pexp[i]));
    end
    $display("test indicator done");
    // Processor stepping, wrap, pointer clear and hardware compare.
    wr(path_monitor_pkg::TCTL_IDX, 8'h02);
    wr(path_monitor_pkg::TCTL_IDX, 8'h03);
    for (i = 0; i < 16; i++) wr(path_monitor_pkg::TDAT_IDX, 8'ha0 + 8'(i));
    rdchk(path_monitor_pkg::TDAT_IDX, 8'ha0);
    rdchk(path_monitor_pkg::TDAT_IDX, 8'ha1);
    wr(path_monitor_pkg::TCTL_IDX, 8'h03);
    rdchk(path_monitor_pkg::TDAT_IDX, 8'ha2);
    wr(path_monitor_pkg::TCTL_IDX, 8'h00);
    wr(path_monitor_pkg::TCTL_IDX, 8'h01);
    frame(8'h00, 8'h00, 8'h00, 8'ha0, 8'h00, 8'h00, 4'h0);
    check(32'(tmis), 32'h0);
    frame(8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 4'h0);
    check(32'(tmis), 32'h1);
    $display("test trace done");
    // Five-frame mismatch threshold, then the long trace string wrap.
    wr(path_monitor_pkg::CFG1_IDX, 8'h66);
    for (i = 0; i < 5; i++) begin
      frame(8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4'h0);
      check(32'(lma), 32'(i == 4));
    end
    wr(path_monitor_pkg::TCTL_IDX, 8'h02);
    wr(path_monitor_pkg::TCTL_IDX, 8'h03);
    for (i = 0; i < 64; i++) begin
      wr(path_monitor_pkg::TDAT_IDX, 8'h40 + 8'(i));
    end
    rdchk(path_monitor_pkg::TDAT_IDX, 8'h40);
    rdchk(path_monitor_pkg::TDAT_IDX, 8'h41);
    $display("test long string done");
    results();
  end
endmodule

`default_nettype wire
